// *** src/rss_pkg.sv ***
/*
  Package for the reset source sequencer: register map, field positions,
  brown-out mode codes, timing constants.
  Assumes a 20 MHz system clock and a 32-bit APB register bus.
*/
package rss_pkg;
  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [11:0] RSS_BOR_CTRL_OFFS = 12'h000; // brownout_control
  localparam logic [11:0] RSS_CAUSE_OFFS = 12'h004; // reset cause flags
  localparam logic [11:0] RSS_STAT_OFFS = 12'h008; // sequencer status
  localparam int RSS_SWEN_BIT = 7;
  localparam int RSS_RDY_BIT = 0;
  localparam logic RSS_SWEN_RST = 1'b1;
  // cause register bit positions
  localparam int RSS_C_STACK_OVER_FLAG = 7;
  localparam int RSS_C_STACK_UNDER_FLAG = 6;
  localparam int RSS_C_MASTER_CLEAR_PIN_N = 3;
  localparam int RSS_C_RI_N = 2;
  localparam int RSS_C_TO_N = 1;
  localparam int RSS_C_PD_N = 0;
  // brown-out mode codes
  localparam logic [1:0] RSS_BOR_OFF = 2'h0;
  localparam logic [1:0] RSS_BOR_SW = 2'h1;
  localparam logic [1:0] RSS_BOR_NSLEEP = 2'h2;
  localparam logic [1:0] RSS_BOR_ON = 2'h3;
  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int RSS_CLK_HZ = 20000000;
  localparam int RSS_POWERUP_TIMER_MS = 64;
  localparam int RSS_POWERUP_TIMER_CYC = (RSS_CLK_HZ / 1000) * RSS_POWERUP_TIMER_MS;
  localparam int RSS_GLITCH_NS = 200;
  localparam int RSS_GLITCH_CYC = (RSS_GLITCH_NS * (RSS_CLK_HZ / 1000000) + 999) / 1000;
  // sequencer states
  typedef enum logic [3:0] {
    RSS_S_RESET = 4'h1,
    RSS_S_WAIT = 4'h2,
    RSS_S_RUN = 4'h4,
    RSS_S_SLEEP = 4'h8
  } rss_state_type;
endpackage

// *** src/rss_sequencer.sv ***
/*
  Reset source sequencer: brown-out mode control, master-clear filter,
  merging of reset sources, power-up timer and start-up ordering.
  Assumes analog monitors and the pin are asynchronous; cpu events
  (watchdog, reset instruction, stack faults) come from the i_mclk domain.
*/
`timescale 1ns/100ps
`default_nettype none

module rss_sequencer (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  // configuration bits
  input wire logic [1:0] i_brownout_mode_cfg,
  input wire logic i_master_clear_pin_en,
  input wire logic i_low_voltage_prog_en,
  input wire logic i_stack_fault_reset_en,
  input wire logic i_powerup_timer_en_n,
  // analog monitors and pin
  input wire logic i_brownout_ready,
  input wire logic i_supply_low,
  input wire logic i_prog_mode,
  input wire logic i_master_clear_pin,
  input wire logic i_gpio_pullup_sw,
  input wire logic i_osc_startup_done,
  // cpu events, mclk domain
  input wire logic i_sleep,
  input wire logic i_watchdog_timeout,
  input wire logic i_reset_instr,
  input wire logic i_stack_over,
  input wire logic i_stack_under,
  // outputs
  output logic o_brownout_enable,
  output logic o_master_clear_pin_o,
  output logic o_master_clear_pin_oe,
  output logic o_weak_pullup_en,
  output logic o_gpio_in,
  output logic o_core_reset_n,
  output logic o_wake_ok
);
  // ----------------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------------
  logic [2:0] rdy_sync_r, low_sync_r, pin_sync_r, prog_sync_r;
  logic rdy_s, low_s, pin_s, prog_s;

  // three stages; a change counts once stages two and three agree
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdy_sync_r <= 3'h0;
      low_sync_r <= 3'h0;
      pin_sync_r <= 3'h7;
      prog_sync_r <= 3'h0;
    end else begin
      rdy_sync_r <= {rdy_sync_r[1:0], i_brownout_ready};
      low_sync_r <= {low_sync_r[1:0], i_supply_low};
      pin_sync_r <= {pin_sync_r[1:0], i_master_clear_pin};
      prog_sync_r <= {prog_sync_r[1:0], i_prog_mode};
    end
  end

  // hold last agreed value while stages disagree
  logic rdy_q_r, low_q_r, pin_q_r, prog_q_r;
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdy_q_r <= 1'b0;
      low_q_r <= 1'b0;
      pin_q_r <= 1'b1;
      prog_q_r <= 1'b0;
    end else begin
      if (rdy_sync_r[1] == rdy_sync_r[2]) rdy_q_r <= rdy_sync_r[2];
      if (low_sync_r[1] == low_sync_r[2]) low_q_r <= low_sync_r[2];
      if (pin_sync_r[1] == pin_sync_r[2]) pin_q_r <= pin_sync_r[2];
      if (prog_sync_r[1] == prog_sync_r[2]) prog_q_r <= prog_sync_r[2];
    end
  end
  assign rdy_s = rdy_q_r;
  assign low_s = low_q_r;
  assign pin_s = pin_q_r;
  assign prog_s = prog_q_r;

  // ----------------------------------------------------------------------
  // brown-out mode control
  // ----------------------------------------------------------------------
  logic sw_brownout_enable_r;
  logic master_clear_pin_enabled;
  logic bor_active, bor_wait, bor_trip;
  logic [1:0] bmode;
  assign bmode = i_brownout_mode_cfg;

  // supervisor enable per mode
  always_comb begin
    case (bmode)
      rss_pkg::RSS_BOR_ON: o_brownout_enable = 1'b1;
      rss_pkg::RSS_BOR_NSLEEP: o_brownout_enable = !i_sleep;
      rss_pkg::RSS_BOR_SW: o_brownout_enable = sw_brownout_enable_r;
      default: o_brownout_enable = 1'b0;
    endcase
  end
  // protection only counts once supervisor is ready
  assign bor_active = o_brownout_enable && rdy_s;
  assign bor_trip = bor_active && low_s;
  // start-up waits on readiness only in the forced modes
  assign bor_wait = (bmode == rss_pkg::RSS_BOR_ON || bmode == rss_pkg::RSS_BOR_NSLEEP)
                    && (!rdy_s || low_s);
  // wake from sleep waits only in off-in-sleep mode
  assign o_wake_ok = (bmode == rss_pkg::RSS_BOR_NSLEEP) ? rdy_s : 1'b1;

  // ----------------------------------------------------------------------
  // master-clear pin
  // ----------------------------------------------------------------------
  assign master_clear_pin_enabled = i_master_clear_pin_en || i_low_voltage_prog_en;
  assign o_master_clear_pin_o = 1'b0;
  assign o_master_clear_pin_oe = 1'b0;
  assign o_weak_pullup_en = master_clear_pin_enabled ? 1'b1 : i_gpio_pullup_sw;
  assign o_gpio_in = master_clear_pin_enabled ? 1'b0 : pin_s;

  // glitch filter: low must persist before reset is taken
  localparam int GW = $clog2(rss_pkg::RSS_GLITCH_CYC + 1);
  localparam logic [GW-1:0] GLITCH_MAX = GW'(rss_pkg::RSS_GLITCH_CYC);
  logic [GW-1:0] glitch_cnt_r;
  logic master_clear_pin_low_r;
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      glitch_cnt_r <= '0;
      master_clear_pin_low_r <= 1'b0;
    end else if (pin_s) begin
      glitch_cnt_r <= '0;
      master_clear_pin_low_r <= 1'b0;
    end else if (glitch_cnt_r == GLITCH_MAX) begin
      master_clear_pin_low_r <= 1'b1;
    end else begin
      glitch_cnt_r <= glitch_cnt_r + 1'b1;
    end
  end
  logic master_clear_pin_hold;
  assign master_clear_pin_hold = master_clear_pin_enabled && master_clear_pin_low_r;

  // ----------------------------------------------------------------------
  // power-up timer
  // ----------------------------------------------------------------------
  localparam int PW = $clog2(rss_pkg::RSS_POWERUP_TIMER_CYC + 1);
  localparam logic [PW-1:0] POWERUP_TIMER_MAX = PW'(rss_pkg::RSS_POWERUP_TIMER_CYC);
  logic [PW-1:0] powerup_timer_cnt_r;
  logic powerup_timer_done;
  logic por_like; // power-on, brown-out or programming exit
  logic prog_d_r;
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) prog_d_r <= 1'b0;
    else prog_d_r <= prog_s;
  end
  // a forced wait in sleep is only a wake-up delay, never a power-on event
  assign por_like = bor_trip || prog_s || prog_d_r ||
                    (bor_wait && state_r != rss_pkg::RSS_S_SLEEP);

  // restarts while cause holds, counts after release regardless of pin
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) powerup_timer_cnt_r <= '0;
    else if (por_like) powerup_timer_cnt_r <= '0;
    else if (powerup_timer_cnt_r != POWERUP_TIMER_MAX) powerup_timer_cnt_r <= powerup_timer_cnt_r + 1'b1;
  end
  assign powerup_timer_done = i_powerup_timer_en_n || (powerup_timer_cnt_r == POWERUP_TIMER_MAX);

  // ----------------------------------------------------------------------
  // synchronous reset events
  // ----------------------------------------------------------------------
  logic stk_rst, sync_evt;
  assign stk_rst = i_stack_fault_reset_en && (i_stack_over || i_stack_under);
  assign sync_evt = i_watchdog_timeout || i_reset_instr || stk_rst;

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  rss_pkg::rss_state_type state_r;
  logic start_ok;
  assign start_ok = powerup_timer_done && i_osc_startup_done && !master_clear_pin_hold && !bor_wait;

  // one state per phase; any reset source drops back to reset
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) state_r <= rss_pkg::RSS_S_RESET;
    else if (por_like || master_clear_pin_hold || sync_evt) state_r <= rss_pkg::RSS_S_RESET;
    else begin
      case (state_r)
        rss_pkg::RSS_S_RESET: state_r <= rss_pkg::RSS_S_WAIT;
        rss_pkg::RSS_S_WAIT: if (start_ok) state_r <= rss_pkg::RSS_S_RUN;
        rss_pkg::RSS_S_RUN: if (i_sleep) state_r <= rss_pkg::RSS_S_SLEEP;
        rss_pkg::RSS_S_SLEEP: if (!i_sleep && o_wake_ok) state_r <= rss_pkg::RSS_S_RUN;
        default: state_r <= rss_pkg::RSS_S_RESET;
      endcase
    end
  end
  // reset assert follows the state one clock edge after the source; release takes two or more edges, via wait
  assign o_core_reset_n = (state_r == rss_pkg::RSS_S_RUN) ||
                          (state_r == rss_pkg::RSS_S_SLEEP);

  // ----------------------------------------------------------------------
  // cause flags (set wins over software write)
  // ----------------------------------------------------------------------
  logic stk_ovf_r, stk_unf_r, master_clear_pin_n_r, ri_n_r, to_n_r, pd_n_r;
  logic wr_cause, wr_ctrl, acc;
  assign acc = i_psel && i_penable;
  assign wr_cause = acc && i_pwrite && i_paddr == rss_pkg::RSS_CAUSE_OFFS;
  assign wr_ctrl = acc && i_pwrite && i_paddr == rss_pkg::RSS_BOR_CTRL_OFFS;

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      stk_ovf_r <= 1'b0;
      stk_unf_r <= 1'b0;
      master_clear_pin_n_r <= 1'b1;
      ri_n_r <= 1'b1;
      to_n_r <= 1'b1;
      pd_n_r <= 1'b1;
    end else if (por_like) begin
      stk_ovf_r <= 1'b0;
      stk_unf_r <= 1'b0;
      master_clear_pin_n_r <= 1'b1;
      ri_n_r <= 1'b1;
      to_n_r <= 1'b1;
      pd_n_r <= 1'b1;
    end else begin
      if (i_stack_fault_reset_en && i_stack_over) stk_ovf_r <= 1'b1;
      else if (wr_cause) stk_ovf_r <= i_pwdata[rss_pkg::RSS_C_STACK_OVER_FLAG];
      if (i_stack_fault_reset_en && i_stack_under) stk_unf_r <= 1'b1;
      else if (wr_cause) stk_unf_r <= i_pwdata[rss_pkg::RSS_C_STACK_UNDER_FLAG];
      if (master_clear_pin_hold) master_clear_pin_n_r <= 1'b0;
      else if (wr_cause) master_clear_pin_n_r <= i_pwdata[rss_pkg::RSS_C_MASTER_CLEAR_PIN_N];
      if (i_reset_instr) ri_n_r <= 1'b0;
      else if (wr_cause) ri_n_r <= i_pwdata[rss_pkg::RSS_C_RI_N];
      if (i_watchdog_timeout) begin
        to_n_r <= 1'b0;
        pd_n_r <= !i_sleep;
      end
    end
  end

  // ----------------------------------------------------------------------
  // apb slave: zero wait states
  // ----------------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) sw_brownout_enable_r <= rss_pkg::RSS_SWEN_RST;
    else if (wr_ctrl) sw_brownout_enable_r <= i_pwdata[rss_pkg::RSS_SWEN_BIT];
  end

  logic [31:0] rdata;
  logic hit;
  always_comb begin
    rdata = 32'h0;
    hit = 1'b1;
    case (i_paddr)
      rss_pkg::RSS_BOR_CTRL_OFFS: begin
        rdata[rss_pkg::RSS_SWEN_BIT] = sw_brownout_enable_r;
        rdata[rss_pkg::RSS_RDY_BIT] = bor_active;
      end
      rss_pkg::RSS_CAUSE_OFFS: begin
        rdata[rss_pkg::RSS_C_STACK_OVER_FLAG] = stk_ovf_r;
        rdata[rss_pkg::RSS_C_STACK_UNDER_FLAG] = stk_unf_r;
        rdata[rss_pkg::RSS_C_MASTER_CLEAR_PIN_N] = master_clear_pin_n_r;
        rdata[rss_pkg::RSS_C_RI_N] = ri_n_r;
        rdata[rss_pkg::RSS_C_TO_N] = to_n_r;
        rdata[rss_pkg::RSS_C_PD_N] = pd_n_r;
      end
      rss_pkg::RSS_STAT_OFFS: rdata[3:0] = state_r;
      default: hit = 1'b0;
    endcase
  end
  assign o_pready = 1'b1;
  assign o_pslverr = acc && !hit;
  assign o_prdata = rdata;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_b);

  sequence hold_low_s;
    !pin_s [*3];
  endsequence

  mode_on_en_a: assert property (bmode == rss_pkg::RSS_BOR_ON |-> o_brownout_enable)
    else $error("supervisor off in always-on mode");
  nsleep_off_a: assert property (bmode == rss_pkg::RSS_BOR_NSLEEP && i_sleep
    |-> !o_brownout_enable)
    else $error("supervisor on in sleep");
  sw_mode_a: assert property (bmode == rss_pkg::RSS_BOR_SW
    |-> o_brownout_enable == sw_brownout_enable_r && !bor_wait)
    else $error("software mode wrong");
  off_mode_a: assert property (bmode == rss_pkg::RSS_BOR_OFF
    |-> !o_brownout_enable && o_wake_ok)
    else $error("off mode wrong");
  ready_bit_a: assert property (acc && !i_pwrite && i_paddr == rss_pkg::RSS_BOR_CTRL_OFFS
    |-> o_prdata[6:1] == 6'h0 && o_prdata[0] == bor_active)
    else $error("ready register read wrong");
  pin_never_a: assert property (!o_master_clear_pin_oe)
    else $error("pin driven");
  master_clear_pin_reset_a: assert property (master_clear_pin_enabled && master_clear_pin_hold |=> !o_core_reset_n)
    else $error("no reset with pin low");
  glitch_ign_a: assert property ($rose(pin_s) |-> !master_clear_pin_low_r || $past(glitch_cnt_r)
    == GLITCH_MAX)
    else $error("glitch taken as reset");
  ri_flag_a: assert property (i_reset_instr && !por_like |=> !ri_n_r && !o_core_reset_n)
    else $error("reset instruction flag");
  wdt_flag_a: assert property (i_watchdog_timeout && !por_like |=> !to_n_r)
    else $error("timeout flag");
  stk_gate_a: assert property (!i_stack_fault_reset_en && i_stack_over |=> $stable(stk_ovf_r)
    || $past(wr_cause) || $past(por_like))
    else $error("stack flag without enable");
  start_seq_a: assert property (state_r == rss_pkg::RSS_S_WAIT ##1 o_core_reset_n
    |-> $past(start_ok))
    else $error("start before conditions");
  master_clear_pin_en_a: assert property (!i_master_clear_pin_en && !i_low_voltage_prog_en
    |-> !master_clear_pin_hold && o_weak_pullup_en == i_gpio_pullup_sw)
    else $error("master-clear enable");
  prog_exit_a: assert property (prog_s |=> powerup_timer_cnt_r == '0 && !o_core_reset_n)
    else $error("programming exit not like power-on");
  hold_low_a: assert property (hold_low_s |-> master_clear_pin_low_r || glitch_cnt_r != '0)
    else $error("filter not counting");
endmodule

`default_nettype wire

// *** verif/rss_monitor_model.sv ***
/*
  Far-side model: master-clear pin with its weak pull-up, the brown-out
  supervisor ready output and the supply comparator.
  Assumes the bench commands pin holds and supply dips; ready delay is set
  per test so both prompt and slow supervisors are exercised.
*/
`timescale 1ns/100ps
`default_nettype none

module rss_monitor_model (
  input wire logic i_mclk,
  input wire logic i_drive_low,
  input wire logic i_pin_o,
  input wire logic i_pin_oe,
  input wire logic i_bor_en,
  input wire logic [7:0] i_ready_delay,
  input wire logic i_supply_dip,
  output logic o_pin,
  output logic o_ready,
  output logic o_supply_low
);
  logic [7:0] warm_r;

  // ----------------------------------------------------------------------
  // pin level
  // ----------------------------------------------------------------------
  // released pin floats up through the weak pull-up, never holds old value
  assign o_pin = i_pin_oe ? i_pin_o : !i_drive_low;

  // ----------------------------------------------------------------------
  // supervisor
  // ----------------------------------------------------------------------
  // warm-up count restarts whenever the supervisor is switched off
  always_ff @(posedge i_mclk) begin
    if (!i_bor_en) begin
      warm_r <= 8'h00;
    end else if (warm_r != 8'hff) begin
      warm_r <= warm_r + 8'h01;
    end
  end
  assign o_ready = i_bor_en && (warm_r >= i_ready_delay);
  // comparator left raw even when off: harsher than a quiet monitor
  assign o_supply_low = i_supply_dip;
endmodule

`default_nettype wire

// *** verif/tb_reset_source_sequencer.sv ***
/*
  Self-checking bench for the reset source sequencer.
  Assumes the power-up timer is bypassed (enable tied off) to keep the run short.
*/
`timescale 1ns/100ps
`default_nettype none

module tb_reset_source_sequencer;
  localparam logic [11:0] CTRL = rss_pkg::RSS_BOR_CTRL_OFFS;
  localparam logic [11:0] CAUSE = rss_pkg::RSS_CAUSE_OFFS;
  logic mclk = 1'b0;
  logic rst_b, psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [1:0] mode;
  logic pin_en, low_voltage_prog_en, stk_en, prog, pullup_sw, osc_done, sleep, wdt, rst_instr;
  logic stk_over, stk_under, bor_ready, supply_low, pin, pin_o, pin_oe;
  logic bor_en, wpu_en, gpio_in, core_n, wake_ok, drive_low, dip;
  logic [7:0] rdy_dly;
  int num_errors = 0;
  int checked = 0;
  int seed = 32'h055dca75;

  always #25 mclk = ~mclk;

  rss_sequencer u_rss_sequencer (.i_mclk(mclk), .i_rst_b(rst_b), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
    .i_brownout_mode_cfg(mode), .i_master_clear_pin_en(pin_en),
    .i_low_voltage_prog_en(low_voltage_prog_en), .i_stack_fault_reset_en(stk_en),
    .i_powerup_timer_en_n(1'b1), .i_brownout_ready(bor_ready), .i_supply_low(supply_low),
    .i_prog_mode(prog), .i_master_clear_pin(pin), .i_gpio_pullup_sw(pullup_sw),
    .i_osc_startup_done(osc_done), .i_sleep(sleep), .i_watchdog_timeout(wdt),
    .i_reset_instr(rst_instr), .i_stack_over(stk_over), .i_stack_under(stk_under),
    .o_brownout_enable(bor_en), .o_master_clear_pin_o(pin_o),
    .o_master_clear_pin_oe(pin_oe), .o_weak_pullup_en(wpu_en), .o_gpio_in(gpio_in),
    .o_core_reset_n(core_n), .o_wake_ok(wake_ok));

  rss_monitor_model u_rss_monitor_model (.i_mclk(mclk), .i_drive_low(drive_low),
    .i_pin_o(pin_o), .i_pin_oe(pin_oe), .i_bor_en(bor_en), .i_ready_delay(rdy_dly),
    .i_supply_dip(dip), .o_pin(pin), .o_ready(bor_ready), .o_supply_low(supply_low));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) num_errors++;
  endtask

  // bounded wait for the core reset level
  task automatic wait_core(input logic v);
    int n;
    n = 0;
    while (core_n !== v && n < 400) begin
      @(posedge mclk);
      n++;
    end
  endtask

  // one-cycle pulse on {stack under, stack over, reset instr, watchdog}
  task automatic fire(input logic [3:0] w);
    @(posedge mclk);
    {stk_under, stk_over, rst_instr, wdt} <= w;
    @(posedge mclk);
    {stk_under, stk_over, rst_instr, wdt} <= 4'h0;
  endtask

  function automatic logic exp_en(input logic [3:0] v);
    case (v[3:2])
      rss_pkg::RSS_BOR_ON: return 1'b1;
      rss_pkg::RSS_BOR_NSLEEP: return !v[1];
      rss_pkg::RSS_BOR_SW: return v[0];
      default: return 1'b0;
    endcase
  endfunction

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial begin
    logic [3:0] v;
    {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
    {mode, pin_en, low_voltage_prog_en, stk_en, prog, pullup_sw, osc_done, sleep} = '0;
    {wdt, rst_instr, stk_over, stk_under, drive_low, dip} = '0;
    rdy_dly = 8'h02;
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    apb(1'b0, CTRL, 32'h0);
    chk(rdat, {24'h0, rss_pkg::RSS_SWEN_RST, 7'h0});
    apb(1'b0, CAUSE, 32'h0);
    chk(rdat, 32'h0000000f);
    apb(1'b0, 12'h00c, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    chk(rdat, 32'h0);
    repeat (40) @(posedge mclk);
    chk(core_n, 1'b0);
    osc_done <= 1'b1;
    wait_core(1'b1);
    chk(core_n, 1'b1);
    apb(1'b0, rss_pkg::RSS_STAT_OFFS, 32'h0);
    chk(rdat, {28'h0, rss_pkg::RSS_S_RUN});
    $display("test startup done");
    // every mode, sleep and enable combination, then random ones
    for (int i = 0; i < 24; i++) begin
      v = (i < 16) ? i[3:0] : 4'($random(seed));
      @(posedge mclk);
      mode <= v[3:2];
      sleep <= v[1];
      rdy_dly <= {3'h0, 5'($random(seed))};
      apb(1'b1, CTRL, {24'h0, v[0], 7'h0});
      repeat (45) @(posedge mclk);
      chk(bor_en, exp_en(v));
      apb(1'b0, CTRL, 32'h0);
      chk(rdat, {24'h0, v[0], 6'h0, exp_en(v)});
    end
    $display("test modes done");
    mode <= rss_pkg::RSS_BOR_NSLEEP;
    sleep <= 1'b0;
    rdy_dly <= 8'd20;
    repeat (60) @(posedge mclk);
    sleep <= 1'b1;
    repeat (10) @(posedge mclk);
    sleep <= 1'b0;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    chk(wake_ok, 1'b0);
    repeat (60) @(posedge mclk);
    chk(wake_ok, 1'b1);
    mode <= rss_pkg::RSS_BOR_ON;
    repeat (60) @(posedge mclk);
    sleep <= 1'b1;
    repeat (10) @(posedge mclk);
    sleep <= 1'b0;
    @(negedge mclk);
    chk(wake_ok, 1'b1);
    $display("test wake done");
    // supply dip resets only while the supervisor is on
    for (int m = 0; m < 2; m++) begin
      mode <= m[0] ? rss_pkg::RSS_BOR_ON : rss_pkg::RSS_BOR_OFF;
      repeat (40) @(posedge mclk);
      dip <= 1'b1;
      repeat (20) @(posedge mclk);
      chk(core_n, !m[0]);
      dip <= 1'b0;
      wait_core(1'b1);
      chk(core_n, 1'b1);
    end
    $display("test supply done");
    // master-clear enable table, each with a long pin hold
    for (int k = 0; k < 4; k++) begin
      pin_en <= k[1];
      low_voltage_prog_en <= k[0];
      pullup_sw <= 1'($random(seed));
      repeat (12) @(posedge mclk);
      chk(gpio_in, !(k[1] | k[0]));
      chk(wpu_en, (k[1] | k[0]) ? 1'b1 : pullup_sw);
      drive_low <= 1'b1;
      repeat (20) @(posedge mclk);
      chk(core_n, !(k[1] | k[0]));
      chk(pin_oe, 1'b0);
      drive_low <= 1'b0;
      wait_core(1'b1);
      chk(core_n, 1'b1);
    end
    apb(1'b0, CAUSE, 32'h0);
    chk(rdat[3], 1'b0);
    drive_low <= 1'b1;
    repeat (2) @(posedge mclk);
    drive_low <= 1'b0;
    repeat (15) @(posedge mclk);
    chk(core_n, 1'b1);
    $display("test master clear done");
    fire(4'h1);
    wait_core(1'b0);
    chk(core_n, 1'b0);
    wait_core(1'b1);
    apb(1'b0, CAUSE, 32'h0);
    chk(rdat[1:0], 2'b01);
    fire(4'h2);
    wait_core(1'b0);
    wait_core(1'b1);
    apb(1'b0, CAUSE, 32'h0);
    chk(rdat[2], 1'b0);
    fire(4'h4);
    repeat (20) @(posedge mclk);
    chk(core_n, 1'b1);
    stk_en <= 1'b1;
    fire(4'h4);
    wait_core(1'b0);
    chk(core_n, 1'b0);
    wait_core(1'b1);
    fire(4'h8);
    wait_core(1'b0);
    wait_core(1'b1);
    apb(1'b0, CAUSE, 32'h0);
    chk(rdat[7:6], 2'b11);
    apb(1'b1, CAUSE, 32'h0000000c);
    apb(1'b0, CAUSE, 32'h0);
    chk(rdat[7:2], 6'b000011);
    $display("test cpu events done");
    prog <= 1'b1;
    repeat (10) @(posedge mclk);
    chk(core_n, 1'b0);
    prog <= 1'b0;
    wait_core(1'b1);
    apb(1'b0, CAUSE, 32'h0);
    chk(rdat, 32'h0000000f);
    $display("test programming exit done");
    tally_and_finish();
  end

  // hang guard, well beyond the few thousand cycles the tests need
  initial begin
    repeat (30000) @(posedge mclk);
    num_errors++;
    tally_and_finish();
  end
endmodule

`default_nettype wire
